// ### hdl/cpfl_pkg.sv
// Operation
// - Junction hot holds channel off; flag low only while its input is high.
// - Junction-hot indication turns the channel off.
// - Channel restarts only once junction drops below restart threshold.
// - Shutdown and restart repeat while overload persists, never latching off.
// - Case hot during junction protection switches off the faulted channels.
// - Case restart waits until faulted junctions and case have both cleared.
// - Fault flag held low while junction event active, released on its reset; the code keeps it low only while that channel's input is also high.
// - Case hot without any junction event leaves the fault flag inactive.
// - Process-supply undervoltage forces outputs off; fault flag holds its level unless a communication error is present.
// - Don't-care outputs keep previous value, e.g. on first communication error.
// - Watchdog timeout disables outputs until a new update arrives.
// - Communication error asserts flag; outputs off at error during refresh.
package cpfl_pkg;
    localparam int CH_NUM = 8;
    // Watchdog timeout, microseconds; value is a plain default.
    localparam int WD_TIMEOUT_US = 100;
    localparam int CLK_MHZ = 20;
    localparam int WD_CYCLES = WD_TIMEOUT_US * CLK_MHZ;
    localparam logic [7:0] CH_OFF = 8'h00;
endpackage

// ### hdl/cpfl_top.sv
`timescale 1ns/1ns
module cpfl_top
(
    // Clock and reset.
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // Channel drive and comparator events.
    input wire logic [7:0] CHANNEL_DRIVE_INPUT_IN,
    input wire logic [7:0] JUNCTION_HOT_IN,
    input wire logic CASE_HOT_IN,
    input wire logic PROCESS_SUPPLY_UV_IN,
    // Logic-side update and communication events.
    input wire logic UPDATE_IN,
    input wire logic COMM_ERROR_IN,
    input wire logic REFRESH_XFER_IN,
    // Outputs.
    output logic [7:0] CHANNEL_SWITCH_OUTPUT_OUT,
    output logic FAULT_N_OUT,
    output logic FAULT_N_OE_N_OUT
);
    logic [7:0] case_off_reg;
    logic wd_expired_reg;
    logic comm_off_reg;
    logic [7:0] case_mask;
    logic [$clog2(cpfl_pkg::WD_CYCLES+1)-1:0] wd_cnt_reg;
    logic [7:0] out_next;
    logic fault_next;

    // ========================================
    // Case over-temperature shutdown state
    // ========================================
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
            case_off_reg <= cpfl_pkg::CH_OFF;
        else if (CASE_HOT_IN)
            case_off_reg <= case_off_reg | JUNCTION_HOT_IN;
        else if ((case_off_reg & JUNCTION_HOT_IN) == cpfl_pkg::CH_OFF)
            case_off_reg <= cpfl_pkg::CH_OFF;
    end

    // ========================================
    // Watchdog
    // ========================================
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            wd_cnt_reg <= '0;
            wd_expired_reg <= 1'h0;
        end
        else if (UPDATE_IN)
        begin
            wd_cnt_reg <= '0;
            wd_expired_reg <= 1'h0;
        end
        else if (wd_cnt_reg == ($bits(wd_cnt_reg))'(cpfl_pkg::WD_CYCLES - 1))
            wd_expired_reg <= 1'h1;
        else
            wd_cnt_reg <= wd_cnt_reg + 1'h1;
    end

    // ========================================
    // Communication error
    // ========================================
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            comm_off_reg <= 1'h0;
        end
        else
        begin
            // An error during a refresh transfer keeps every output off until a clean update.
            if (COMM_ERROR_IN && REFRESH_XFER_IN)
                comm_off_reg <= 1'h1;
            else if (UPDATE_IN && !COMM_ERROR_IN)
                comm_off_reg <= 1'h0;
        end
    end

    // ========================================
    // Output decision
    // ========================================
    always_comb
    begin
        // A latched case shutdown drops in the same cycle that its release condition holds.
        if (CASE_HOT_IN || (case_off_reg & JUNCTION_HOT_IN) != cpfl_pkg::CH_OFF)
            case_mask = case_off_reg;
        else
            case_mask = cpfl_pkg::CH_OFF;
        // Junction hot gates each channel; restart is the comparator's own hysteresis.
        out_next = CHANNEL_DRIVE_INPUT_IN & ~JUNCTION_HOT_IN & ~case_mask;
        // Frozen outputs still obey the thermal protections.
        if (COMM_ERROR_IN && !REFRESH_XFER_IN)
            out_next = CHANNEL_SWITCH_OUTPUT_OUT & ~JUNCTION_HOT_IN & ~case_mask;
        if (PROCESS_SUPPLY_UV_IN || wd_expired_reg || comm_off_reg
            || (COMM_ERROR_IN && REFRESH_XFER_IN))
            out_next = cpfl_pkg::CH_OFF;
        fault_next = ~(|(JUNCTION_HOT_IN & CHANNEL_DRIVE_INPUT_IN) || COMM_ERROR_IN);
        if (PROCESS_SUPPLY_UV_IN && !COMM_ERROR_IN)
            fault_next = FAULT_N_OUT;
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            CHANNEL_SWITCH_OUTPUT_OUT <= cpfl_pkg::CH_OFF;
            FAULT_N_OUT <= 1'h1;
            FAULT_N_OE_N_OUT <= 1'h1;
        end
        else
        begin
            CHANNEL_SWITCH_OUTPUT_OUT <= out_next;
            FAULT_N_OUT <= fault_next;
            FAULT_N_OE_N_OUT <= fault_next;
        end
    end

    // ========================================
    // Assertions
    // ========================================
    property p_junction_off;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        JUNCTION_HOT_IN[0] |=> !CHANNEL_SWITCH_OUTPUT_OUT[0];
    endproperty
    a_junction_off: assert property (p_junction_off) else $error("hot channel on");

    property p_fault_drive;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (JUNCTION_HOT_IN[0] && CHANNEL_DRIVE_INPUT_IN[0] && !PROCESS_SUPPLY_UV_IN) |=> !FAULT_N_OUT;
    endproperty
    a_fault_drive: assert property (p_fault_drive) else $error("fault not low");

    property p_normal;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (JUNCTION_HOT_IN == 8'h00 && !CASE_HOT_IN && !COMM_ERROR_IN && !PROCESS_SUPPLY_UV_IN
            && !wd_expired_reg && !comm_off_reg && !$past(PROCESS_SUPPLY_UV_IN))
        |=> (CHANNEL_SWITCH_OUTPUT_OUT == $past(CHANNEL_DRIVE_INPUT_IN)) && FAULT_N_OUT;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mismatch");

    property p_uv_off;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        PROCESS_SUPPLY_UV_IN && !COMM_ERROR_IN |=> CHANNEL_SWITCH_OUTPUT_OUT == 8'h00
            && FAULT_N_OUT == $past(FAULT_N_OUT);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("uvlo wrong");

    property p_case_no_fault;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        CASE_HOT_IN && JUNCTION_HOT_IN == 8'h00 && !COMM_ERROR_IN && !PROCESS_SUPPLY_UV_IN
        |=> FAULT_N_OUT;
    endproperty
    a_case_no_fault: assert property (p_case_no_fault) else $error("case flagged");

    property p_case_hold;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        CASE_HOT_IN && JUNCTION_HOT_IN[0] ##1 CASE_HOT_IN [*2] |=> !CHANNEL_SWITCH_OUTPUT_OUT[0];
    endproperty
    a_case_hold: assert property (p_case_hold) else $error("case channel on");

    property p_wd;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        wd_expired_reg && !UPDATE_IN |=> CHANNEL_SWITCH_OUTPUT_OUT == 8'h00;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog outputs on");

    property p_comm_fault;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        COMM_ERROR_IN |=> !FAULT_N_OUT && !FAULT_N_OE_N_OUT;
    endproperty
    a_comm_fault: assert property (p_comm_fault) else $error("comm flag missing");

    property p_comm_hold;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        COMM_ERROR_IN && !REFRESH_XFER_IN && !PROCESS_SUPPLY_UV_IN && !wd_expired_reg
            && JUNCTION_HOT_IN == 8'h00 && !comm_off_reg |=> $stable(CHANNEL_SWITCH_OUTPUT_OUT);
    endproperty
    a_comm_hold: assert property (p_comm_hold) else $error("outputs moved");

    property p_fault_or;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (|(JUNCTION_HOT_IN & CHANNEL_DRIVE_INPUT_IN) && !PROCESS_SUPPLY_UV_IN) || COMM_ERROR_IN
        |=> !FAULT_N_OE_N_OUT;
    endproperty
    a_fault_or: assert property (p_fault_or) else $error("open drain not driven");

    property p_fault_release;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (JUNCTION_HOT_IN & CHANNEL_DRIVE_INPUT_IN) == 8'h00 && !COMM_ERROR_IN
            && !PROCESS_SUPPLY_UV_IN |=> FAULT_N_OUT && FAULT_N_OE_N_OUT;
    endproperty
    a_fault_release: assert property (p_fault_release) else $error("fault not released");

    property p_refresh_error_off;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        COMM_ERROR_IN && REFRESH_XFER_IN |=> CHANNEL_SWITCH_OUTPUT_OUT == 8'h00;
    endproperty
    a_refresh_error_off: assert property (p_refresh_error_off) else $error("outputs on");

    property p_comm_latch;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        comm_off_reg |=> CHANNEL_SWITCH_OUTPUT_OUT == 8'h00;
    endproperty
    a_comm_latch: assert property (p_comm_latch) else $error("latched outputs on");

    property p_case_release;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        case_off_reg[0] && (CASE_HOT_IN || JUNCTION_HOT_IN[0]) |=> !CHANNEL_SWITCH_OUTPUT_OUT[0];
    endproperty
    a_case_release: assert property (p_case_release) else $error("early case restart");

    property p_restart;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        CHANNEL_DRIVE_INPUT_IN[0] && !JUNCTION_HOT_IN[0] && !case_off_reg[0] && !COMM_ERROR_IN
            && !PROCESS_SUPPLY_UV_IN && !wd_expired_reg && !comm_off_reg
        |=> CHANNEL_SWITCH_OUTPUT_OUT[0];
    endproperty
    a_restart: assert property (p_restart) else $error("channel not restarted");

    c_junction: cover property (@(posedge CLOCK_IN) JUNCTION_HOT_IN[0] ##1 !JUNCTION_HOT_IN[0]);
    c_case: cover property (@(posedge CLOCK_IN) case_off_reg != 8'h00);
    c_wd: cover property (@(posedge CLOCK_IN) wd_expired_reg);
    c_comm: cover property (@(posedge CLOCK_IN) comm_off_reg);
    c_case_release: cover property (@(posedge CLOCK_IN)
        case_off_reg != 8'h00 ##1 case_off_reg == 8'h00);
endmodule // cpfl_top

// ### bench/cpfl_host_model.sv
`timescale 1ns/1ns
// ==========
// Host model: periodic refresh pulses and the pulled-up fault line.
module cpfl_host_model
(
    // Clock.
    input wire logic clock_in,
    // Control and observed pin.
    input wire logic refresh_en_in,
    input wire logic fault_oe_n_in,
    // Outputs.
    output logic update_out = 1'b0,
    output logic fault_pin_out
);
    int cnt_reg = 0;
    assign fault_pin_out = fault_oe_n_in ? 1'b1 : 1'b0;
    always @(posedge clock_in)
    begin
        cnt_reg <= #1 (cnt_reg + 1) % 100;
        update_out <= #1 refresh_en_in && (cnt_reg == 0);
    end
endmodule // cpfl_host_model

// ### bench/cpfl_top_test.sv
`timescale 1ns/1ns
module cpfl_top_test;
    logic clk = 0, rst_n = 0, cs = 0, uv = 0, ce = 0, rx = 0, ren = 1, upd;
    logic [7:0] drv = 8'h00, jh = 8'h00, out;
    logic fault, oe_n, pin;
    int fails = 0, samples_checked = 0;
    always #25 clk = ~clk;
    cpfl_top dut(.CLOCK_IN(clk), .RST_N_IN(rst_n), .CHANNEL_DRIVE_INPUT_IN(drv),
        .JUNCTION_HOT_IN(jh), .CASE_HOT_IN(cs), .PROCESS_SUPPLY_UV_IN(uv),
        .UPDATE_IN(upd), .COMM_ERROR_IN(ce), .REFRESH_XFER_IN(rx),
        .CHANNEL_SWITCH_OUTPUT_OUT(out), .FAULT_N_OUT(fault), .FAULT_N_OE_N_OUT(oe_n));
    cpfl_host_model host(.clock_in(clk), .refresh_en_in(ren), .fault_oe_n_in(oe_n),
        .update_out(upd), .fault_pin_out(pin));
    // ==========
    // Shared tasks.
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wait_out(input logic [7:0] exp);
        for (int i = 0; i < 300 && out !== exp; i++)
            step(1);
        chk(out, exp);
        if (out !== exp)
            conclude;
    endtask
    // ==========
    // Scenarios.
    task t_normal;
        drv = 8'hA5;
        step(1);
        chk(out, 8'hA5);
        chk({7'h00, pin}, 8'h01);
        $display("normal operation done");
    endtask
    task t_junction;
        drv = 8'hFF;
        repeat (2)
        begin
            jh = 8'h01;
            step(1);
            chk(out, 8'hFE);
            chk({7'h00, pin}, 8'h00);
            drv = 8'hFE;
            step(1);
            chk({7'h00, fault}, 8'h01);
            drv = 8'hFF;
            step(1);
            chk({7'h00, fault}, 8'h00);
            jh = 8'h00;
            step(1);
            chk(out, 8'hFF);
            chk({7'h00, fault}, 8'h01);
        end
        $display("junction shutdown and restart done");
    endtask
    task t_case;
        cs = 1;
        step(1);
        chk({7'h00, pin}, 8'h01);
        cs = 0;
        jh = 8'h01;
        step(1);
        cs = 1;
        step(1);
        jh = 8'h00;
        step(1);
        chk(out, 8'hFE);
        chk({7'h00, fault}, 8'h01);
        cs = 0;
        step(1);
        chk(out, 8'hFF);
        $display("case protection done");
    endtask
    task t_uv;
        jh = 8'h01;
        step(1);
        uv = 1;
        jh = 8'h00;
        step(1);
        chk(out, 8'h00);
        chk({7'h00, fault}, 8'h00);
        uv = 0;
        step(1);
        chk(out, 8'hFF);
        $display("undervoltage lockout done");
    endtask
    task t_comm;
        ren = 0;
        drv = 8'hF0;
        step(1);
        ce = 1;
        drv = 8'h0F;
        step(1);
        chk(out, 8'hF0);
        chk({7'h00, pin}, 8'h00);
        rx = 1;
        step(1);
        chk(out, 8'h00);
        ce = 0;
        rx = 0;
        step(2);
        chk(out, 8'h00);
        ren = 1;
        wait_out(8'h0F);
        $display("communication error done");
    endtask
    task t_watchdog;
        ren = 0;
        step(cpfl_pkg::WD_CYCLES + 1);
        chk(out, 8'h00);
        ren = 1;
        wait_out(8'h0F);
        $display("watchdog done");
    endtask
    initial
    begin
        step(2);
        chk(out, 8'h00);
        rst_n = 1;
        t_normal;
        t_junction;
        t_case;
        t_uv;
        t_comm;
        t_watchdog;
        conclude;
    end
endmodule // cpfl_top_test
